// >>> include/apcs_defs.svh
`ifndef APCS_DEFS_SVH
`define APCS_DEFS_SVH

// Register addresses on the special-function bus
`define APCS_ADDR_TMR_CTRL 8'ha3
`define APCS_ADDR_PIN_SEL 8'ha4
`define APCS_ADDR_PAGE_IDX 8'hac

// Pages that share the pin-select address
`define APCS_PAGE_SEL0 4'h0
`define APCS_PAGE_SEL1 4'h1
`define APCS_PAGE_CAP 4'h2

// Reset values
`define APCS_RST_TMR_CTRL 8'h00
`define APCS_RST_PIN_SEL0 8'h00
`define APCS_RST_PIN_SEL1 8'h00
`define APCS_RST_CAP_SEL 8'h00
`define APCS_RST_PAGE 4'h0

// Timer clock control fields
`define APCS_B_START 7
`define APCS_B_STOP 6
`define APCS_B_LOCK 4
`define APCS_B_TIMER1_FAST_CLOCK_SEL 3
`define APCS_B_TIMER0_FAST_CLOCK_SEL 2
`define APCS_B_TIMER1_CLOCK_OUT_EN 1
`define APCS_B_TIMER0_CLOCK_OUT_EN 0
`define APCS_MASK_TMR_CTRL 8'hdf

// Pin select page 0 fields
`define APCS_F_T0PS 7:6
`define APCS_F_BEEP 5:4
`define APCS_B_S0PS 3
`define APCS_F_TWIPS 2:1
`define APCS_B_TIMER0_EXTENDED_CLOCK_SEL 0

// Pin select page 1 fields
`define APCS_F_T2PS 7:6
`define APCS_F_T1PS 5:4
`define APCS_B_SPIPS 3
`define APCS_B_CMPOE 1
`define APCS_B_CMPFLT 0
`define APCS_MASK_PIN_SEL1 8'hfb

// Capture pin select fields
`define APCS_B_C4S 7
`define APCS_B_C2S 6
`define APCS_B_PPS1 5
`define APCS_B_PPS0 4
`define APCS_B_PS1 3

// Prescaler terminal counts
`define APCS_DIV12_LAST 4'd11
`define APCS_DIV48_LAST 2'd3
`define APCS_DIV192_LAST 2'd3

// Routed pins, index into the pin vectors
`define APCS_NPIN 21
`define APCS_P1_0 5'd0
`define APCS_P1_1 5'd1
`define APCS_P1_4 5'd2
`define APCS_P1_5 5'd3
`define APCS_P1_6 5'd4
`define APCS_P1_7 5'd5
`define APCS_P2_0 5'd6
`define APCS_P2_1 5'd7
`define APCS_P2_2 5'd8
`define APCS_P2_4 5'd9
`define APCS_P2_6 5'd10
`define APCS_P3_0 5'd11
`define APCS_P3_1 5'd12
`define APCS_P3_4 5'd13
`define APCS_P3_5 5'd14
`define APCS_P4_0 5'd15
`define APCS_P4_1 5'd16
`define APCS_P4_4 5'd17
`define APCS_P4_5 5'd18
`define APCS_P6_0 5'd19
`define APCS_P6_1 5'd20

// Routed functions, index into the function vectors
`define APCS_NFUNC 18
`define APCS_FN_T0 0
`define APCS_FN_T1 1
`define APCS_FN_T2 2
`define APCS_FN_TIMER2_EXT_TRIGGER 3
`define APCS_FN_RXD 4
`define APCS_FN_TXD 5
`define APCS_FN_SCL 6
`define APCS_FN_SDA 7
`define APCS_FN_SS 8
`define APCS_FN_MOSI 9
`define APCS_FN_MISO 10
`define APCS_FN_SCK 11
`define APCS_FN_PWM_TWO_OUT_A 12
`define APCS_FN_PWM_TWO_OUT_B 13
`define APCS_FN_PWM_ZERO_OUT_A 14
`define APCS_FN_PWM_ZERO_OUT_B 15
`define APCS_FN_CH3 16
`define APCS_FN_CH5 17

`endif

// >>> include/apcs_pkg.sv
`include "apcs_defs.svh"
package apcs_pkg;
    typedef logic [4:0] apcs_pin_t;

    typedef struct packed {
        logic [7:0] tmr_ctrl;
        logic [7:0] pin_sel0;
        logic [7:0] pin_sel1;
        logic [7:0] cap_sel;
        logic [3:0] page;
        logic [7:0] rdata;
        logic [3:0] div12;
        logic [1:0] div48;
        logic [1:0] div192;
        logic [`APCS_NPIN-1:0] pin_s1;
        logic [`APCS_NPIN-1:0] pin_s2;
        logic [2:0] misc_s1;
        logic [2:0] misc_s2;
        logic osc_prev;
        logic t0_prev;
        logic t1_prev;
        logic t0_tick;
        logic t1_tick;
        logic load;
        logic ch4;
        logic ch2;
        logic [`APCS_NFUNC-1:0] sense;
        logic [`APCS_NPIN-1:0] drive;
        logic [`APCS_NPIN-1:0] oe;
        logic [`APCS_NPIN-1:0] alt;
    } apcs_core_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic beep;
    } apcs_beep_t;
endpackage : apcs_pkg

// >>> design/apcs_beeper.sv
module apcs_beeper (
    input wire logic core_clk_in, // System clock
    input wire logic sys_rst_in, // Synchronous reset
    input wire logic osc_rise_in, // One pulse per oscillator rise
    input wire logic [1:0] ctrl_in, // Beeper divide code
    output logic beep_out // Divided oscillator
);
    apcs_pkg::apcs_beep_t q;
    apcs_pkg::apcs_beep_t n;

    // Count oscillator rises, tap the divider bit
    always_comb begin
        n = q;
        if (ctrl_in == 2'b00) begin
            n.cnt = 5'h00;
            n.beep = 1'b0;
        end else begin
            if (osc_rise_in) begin
                n.cnt = q.cnt + 5'h01;
            end
            case (ctrl_in) // [R11]
                2'b01: n.beep = q.cnt[4];
                2'b10: n.beep = q.cnt[3];
                default: n.beep = q.cnt[2];
            endcase
        end
        if (sys_rst_in) begin
            n = '0;
        end
    end

    // State register
    always_ff @(posedge core_clk_in) begin
        q <= n;
    end

    assign beep_out = q.beep;
endmodule : apcs_beeper

// >>> design/apcs_top.sv
// Contract
// R1: Start seen flag set by hardware, zero-write clears
// R2: Stop seen flag set by hardware, zero-write clears
// R3: Software writes zero to timer control bit five
// R4: Lock bit inhibits buffered update on overflow
// R5: Async timer clocks below half system clock
// R6: Timer one clock chosen from two bits
// R7: Timer zero clock chosen from three bits
// R8: Timer one clock output only when enabled
// R9: Timer zero clock output only when enabled
// R10: Timer zero pin chosen among four pins
// R11: Beeper drives divided oscillator onto P4.4; the code takes the P4.4 output enable from gpio_oe_in
// R12: Serial port pins chosen by one bit
// R13: Two-wire pins chosen among four pairs
// R14: Timer two pins chosen among four pairs
// R15: Timer one pins, code two is reserved
// R16: SPI pins chosen by one bit
// R17: Comparator output onto P6.1 when enabled
// R18: Channel four from pin or comparator
// R19: Channel two from pin or oscillator
// R20: PWM two pair pins chosen by bit
// R21: PWM zero pair pins chosen by bit
// R22: Channels three and five pins by bit
// R23: Page index picks register at shared address
// R24: Unclaimed pins stay general I/O, one pin each
`include "apcs_defs.svh"
module apcs_top (
    input wire logic core_clk_in, // System clock
    input wire logic sys_rst_in, // Synchronous reset, high
    input wire logic [7:0] sfr_addr_in, // Register address
    input wire logic sfr_wr_in, // Write strobe
    input wire logic sfr_rd_in, // Read strobe
    input wire logic [7:0] sfr_wdata_in, // Write data
    output logic [7:0] sfr_rdata_out, // Read data, next cycle
    input wire logic bus_start_seen_in, // Start condition pulse
    input wire logic bus_stop_seen_in, // Stop condition pulse
    input wire logic base_overflow_in, // Base timer overflow pulse
    output logic pwm_buffer_load_out, // Buffered value load pulse
    output logic capture_update_lock_out, // Lock bit state
    input wire logic timer0_counter_select_in, // Timer 0 counter mode
    input wire logic timer1_counter_select_in, // Timer 1 counter mode
    input wire logic low_speed_rc_osc_in, // Async oscillator
    input wire logic watchdog_prescaler_in, // Prescaler pulse
    input wire logic timer1_overflow_in, // Timer 1 overflow pulse
    output logic timer0_tick_out, // Timer 0 count pulse
    output logic timer1_tick_out, // Timer 1 count pulse
    input wire logic comparator_output_in, // Comparator result
    input wire logic capture_ch4_pin_in, // Async channel 4 pin
    input wire logic capture_ch2_pin_in, // Async channel 2 pin
    output logic capture_ch4_out, // Channel 4 input
    output logic capture_ch2_out, // Channel 2 input
    output logic comparator_filter_hi_out, // Filter control bit
    input wire logic [`APCS_NFUNC-1:0] func_en_in, // Function active
    input wire logic [`APCS_NFUNC-1:0] func_drive_in, // Function value
    input wire logic [`APCS_NFUNC-1:0] func_oe_in, // Function drives
    output logic [`APCS_NFUNC-1:0] func_sense_out, // Value at its pin
    input wire logic [`APCS_NPIN-1:0] pin_in, // Async pin levels
    input wire logic [`APCS_NPIN-1:0] gpio_drive_in, // Port latch
    input wire logic [`APCS_NPIN-1:0] gpio_oe_in, // Port drive enable
    output logic [`APCS_NPIN-1:0] pin_drive_out, // Pin value
    output logic [`APCS_NPIN-1:0] pin_oe_out, // Pin enable
    output logic [`APCS_NPIN-1:0] pin_alt_out // Pin owned by function
);
    apcs_pkg::apcs_core_t q;
    apcs_pkg::apcs_core_t n;
    apcs_pkg::apcs_pin_t fpin [`APCS_NFUNC];
    logic fok [`APCS_NFUNC];
    logic fclaim [`APCS_NFUNC];
    logic foe [`APCS_NFUNC];
    logic hit [`APCS_NPIN];
    logic hval [`APCS_NPIN];
    logic hoe [`APCS_NPIN];
    logic beep;
    logic osc_rise;
    logic tick12;
    logic tick48;
    logic tick192;
    logic t0_pin;
    logic t1_pin;
    logic [1:0] t1_code;
    logic [2:0] t0_code;

    // Prescaler taps and edge pulses
    assign tick12 = (q.div12 == `APCS_DIV12_LAST);
    assign tick48 = tick12 && (q.div48 == `APCS_DIV48_LAST);
    assign tick192 = tick48 && (q.div192 == `APCS_DIV192_LAST);
    assign osc_rise = q.misc_s2[0] && !q.osc_prev;
    assign t0_pin = q.pin_s2[fpin[`APCS_FN_T0]];
    assign t1_pin = q.pin_s2[fpin[`APCS_FN_T1]];
    assign t1_code = {q.tmr_ctrl[`APCS_B_TIMER1_FAST_CLOCK_SEL], timer1_counter_select_in};
    assign t0_code = {q.pin_sel0[`APCS_B_TIMER0_EXTENDED_CLOCK_SEL], q.tmr_ctrl[`APCS_B_TIMER0_FAST_CLOCK_SEL],
                      timer0_counter_select_in};

    apcs_beeper u_beeper (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .osc_rise_in(osc_rise),
        .ctrl_in(q.pin_sel0[`APCS_F_BEEP]),
        .beep_out(beep)
    );

    // Pin chosen for each routed function
    always_comb begin
        for (int k = 0; k < `APCS_NFUNC; k++) begin
            fpin[k] = `APCS_P1_0;
            fok[k] = 1'b1;
        end
        case (q.pin_sel0[`APCS_F_T0PS]) // [R10]
            2'b00: fpin[`APCS_FN_T0] = `APCS_P3_4;
            2'b01: fpin[`APCS_FN_T0] = `APCS_P4_4;
            2'b10: fpin[`APCS_FN_T0] = `APCS_P2_2;
            default: fpin[`APCS_FN_T0] = `APCS_P2_6;
        endcase
        if (q.pin_sel0[`APCS_B_S0PS]) begin // [R12]
            fpin[`APCS_FN_RXD] = `APCS_P4_4;
            fpin[`APCS_FN_TXD] = `APCS_P4_5;
        end else begin
            fpin[`APCS_FN_RXD] = `APCS_P3_0;
            fpin[`APCS_FN_TXD] = `APCS_P3_1;
        end
        case (q.pin_sel0[`APCS_F_TWIPS]) // [R13]
            2'b00: begin
                fpin[`APCS_FN_SCL] = `APCS_P4_0;
                fpin[`APCS_FN_SDA] = `APCS_P4_1;
            end
            2'b01: begin
                fpin[`APCS_FN_SCL] = `APCS_P6_0;
                fpin[`APCS_FN_SDA] = `APCS_P6_1;
            end
            2'b10: begin
                fpin[`APCS_FN_SCL] = `APCS_P3_0;
                fpin[`APCS_FN_SDA] = `APCS_P3_1;
            end
            default: begin
                fpin[`APCS_FN_SCL] = `APCS_P2_2;
                fpin[`APCS_FN_SDA] = `APCS_P2_4;
            end
        endcase
        case (q.pin_sel1[`APCS_F_T2PS]) // [R14]
            2'b00: begin
                fpin[`APCS_FN_T2] = `APCS_P1_0;
                fpin[`APCS_FN_TIMER2_EXT_TRIGGER] = `APCS_P1_1;
            end
            2'b01: begin
                fpin[`APCS_FN_T2] = `APCS_P3_0;
                fpin[`APCS_FN_TIMER2_EXT_TRIGGER] = `APCS_P3_1;
            end
            2'b10: begin
                fpin[`APCS_FN_T2] = `APCS_P4_0;
                fpin[`APCS_FN_TIMER2_EXT_TRIGGER] = `APCS_P4_1;
            end
            default: begin
                fpin[`APCS_FN_T2] = `APCS_P4_5;
                fpin[`APCS_FN_TIMER2_EXT_TRIGGER] = `APCS_P4_4;
            end
        endcase
        case (q.pin_sel1[`APCS_F_T1PS]) // [R15]
            2'b00: fpin[`APCS_FN_T1] = `APCS_P3_5;
            2'b01: fpin[`APCS_FN_T1] = `APCS_P4_5;
            2'b10: fok[`APCS_FN_T1] = 1'b0;
            default: fpin[`APCS_FN_T1] = `APCS_P2_6;
        endcase
        if (q.pin_sel1[`APCS_B_SPIPS]) begin // [R16]
            fpin[`APCS_FN_SS] = `APCS_P3_4;
            fpin[`APCS_FN_MOSI] = `APCS_P3_5;
            fpin[`APCS_FN_MISO] = `APCS_P4_1;
            fpin[`APCS_FN_SCK] = `APCS_P4_0;
        end else begin
            fpin[`APCS_FN_SS] = `APCS_P1_4;
            fpin[`APCS_FN_MOSI] = `APCS_P1_5;
            fpin[`APCS_FN_MISO] = `APCS_P1_6;
            fpin[`APCS_FN_SCK] = `APCS_P1_7;
        end
        if (q.cap_sel[`APCS_B_PPS1]) begin // [R20]
            fpin[`APCS_FN_PWM_TWO_OUT_A] = `APCS_P3_4;
            fpin[`APCS_FN_PWM_TWO_OUT_B] = `APCS_P3_5;
        end else begin
            fpin[`APCS_FN_PWM_TWO_OUT_A] = `APCS_P4_0;
            fpin[`APCS_FN_PWM_TWO_OUT_B] = `APCS_P4_1;
        end
        if (q.cap_sel[`APCS_B_PPS0]) begin // [R21]
            fpin[`APCS_FN_PWM_ZERO_OUT_A] = `APCS_P6_0;
            fpin[`APCS_FN_PWM_ZERO_OUT_B] = `APCS_P6_1;
        end else begin
            fpin[`APCS_FN_PWM_ZERO_OUT_A] = `APCS_P2_0;
            fpin[`APCS_FN_PWM_ZERO_OUT_B] = `APCS_P2_1;
        end
        if (q.cap_sel[`APCS_B_PS1]) begin // [R22]
            fpin[`APCS_FN_CH3] = `APCS_P2_0;
            fpin[`APCS_FN_CH5] = `APCS_P2_1;
        end else begin
            fpin[`APCS_FN_CH3] = `APCS_P3_4;
            fpin[`APCS_FN_CH5] = `APCS_P3_5;
        end
    end

    // Which functions own a pin and drive it
    always_comb begin
        for (int k = 0; k < `APCS_NFUNC; k++) begin
            fclaim[k] = func_en_in[k] && fok[k];
            foe[k] = func_oe_in[k];
        end
        fclaim[`APCS_FN_T0] = fok[`APCS_FN_T0] && (func_en_in[`APCS_FN_T0]
                              || q.tmr_ctrl[`APCS_B_TIMER0_CLOCK_OUT_EN]);
        fclaim[`APCS_FN_T1] = fok[`APCS_FN_T1] && (func_en_in[`APCS_FN_T1]
                              || q.tmr_ctrl[`APCS_B_TIMER1_CLOCK_OUT_EN]);
        foe[`APCS_FN_T0] = q.tmr_ctrl[`APCS_B_TIMER0_CLOCK_OUT_EN]; // [R9]
        foe[`APCS_FN_T1] = q.tmr_ctrl[`APCS_B_TIMER1_CLOCK_OUT_EN]; // [R8]
    end

    // Per pin owner: beeper, comparator, then lowest function
    for (genvar gp = 0; gp < `APCS_NPIN; gp++) begin : g_pin
        always_comb begin
            hit[gp] = 1'b0;
            hval[gp] = gpio_drive_in[gp]; // [R24]
            hoe[gp] = gpio_oe_in[gp];
            for (int k = `APCS_NFUNC - 1; k >= 0; k--) begin
                if (fclaim[k] && (fpin[k] == 5'(gp))) begin // [R24]
                    hit[gp] = 1'b1;
                    hval[gp] = func_drive_in[k];
                    hoe[gp] = foe[k];
                end
            end
            if ((5'(gp) == `APCS_P6_1) && q.pin_sel1[`APCS_B_CMPOE]) begin
                hit[gp] = 1'b1; // [R17]
                hval[gp] = comparator_output_in;
                hoe[gp] = 1'b1;
            end
            if ((5'(gp) == `APCS_P4_4) &&
                (q.pin_sel0[`APCS_F_BEEP] != 2'b00)) begin
                hit[gp] = 1'b1; // [R11]
                hval[gp] = beep;
                hoe[gp] = gpio_oe_in[gp];
            end
        end
    end

    // Next state of the whole block
    always_comb begin
        n = q;
        n.pin_s1 = pin_in;
        n.pin_s2 = q.pin_s1;
        n.misc_s1 = {capture_ch2_pin_in, capture_ch4_pin_in,
                     low_speed_rc_osc_in};
        n.misc_s2 = q.misc_s1;
        n.osc_prev = q.misc_s2[0];
        n.t0_prev = t0_pin;
        n.t1_prev = t1_pin;
        // Flags: hardware set wins over a zero write
        n.tmr_ctrl[`APCS_B_START] = q.tmr_ctrl[`APCS_B_START] |
                                    bus_start_seen_in; // [R1]
        n.tmr_ctrl[`APCS_B_STOP] = q.tmr_ctrl[`APCS_B_STOP] |
                                   bus_stop_seen_in; // [R2]
        if (sfr_wr_in) begin
            if (sfr_addr_in == `APCS_ADDR_TMR_CTRL) begin
                n.tmr_ctrl[4:0] = sfr_wdata_in[4:0];
                n.tmr_ctrl[5] = 1'b0; // [R3]
                n.tmr_ctrl[`APCS_B_START] = bus_start_seen_in ||
                    (q.tmr_ctrl[`APCS_B_START] &&
                     sfr_wdata_in[`APCS_B_START]); // [R1]
                n.tmr_ctrl[`APCS_B_STOP] = bus_stop_seen_in ||
                    (q.tmr_ctrl[`APCS_B_STOP] &&
                     sfr_wdata_in[`APCS_B_STOP]); // [R2]
            end else if (sfr_addr_in == `APCS_ADDR_PIN_SEL) begin
                if (q.page == `APCS_PAGE_SEL0) begin // [R23]
                    n.pin_sel0 = sfr_wdata_in;
                end else if (q.page == `APCS_PAGE_SEL1) begin
                    n.pin_sel1 = sfr_wdata_in & `APCS_MASK_PIN_SEL1;
                end else if (q.page == `APCS_PAGE_CAP) begin
                    n.cap_sel = sfr_wdata_in;
                end
            end else if (sfr_addr_in == `APCS_ADDR_PAGE_IDX) begin
                n.page = sfr_wdata_in[3:0];
            end
        end
        // Read data, zero for unmapped address or page
        if (sfr_rd_in) begin
            n.rdata = 8'h00;
            if (sfr_addr_in == `APCS_ADDR_TMR_CTRL) begin
                n.rdata = q.tmr_ctrl & `APCS_MASK_TMR_CTRL;
            end else if (sfr_addr_in == `APCS_ADDR_PIN_SEL) begin
                if (q.page == `APCS_PAGE_SEL0) begin // [R23]
                    n.rdata = q.pin_sel0;
                end else if (q.page == `APCS_PAGE_SEL1) begin
                    n.rdata = q.pin_sel1;
                end else if (q.page == `APCS_PAGE_CAP) begin
                    n.rdata = q.cap_sel;
                end
            end else if (sfr_addr_in == `APCS_ADDR_PAGE_IDX) begin
                n.rdata = {4'h0, q.page};
            end
        end
        // Prescaler chain for the divided clocks
        n.div12 = tick12 ? 4'h0 : q.div12 + 4'h1;
        if (tick12) begin
            n.div48 = q.div48 + 2'd1;
        end
        if (tick48) begin
            n.div192 = q.div192 + 2'd1;
        end
        // Timer 1 source, pin counts falling edges [R5]
        case (t1_code) // [R6]
            2'b00: n.t1_tick = tick12;
            2'b01: n.t1_tick = q.t1_prev && !t1_pin;
            2'b10: n.t1_tick = 1'b1;
            default: n.t1_tick = tick48;
        endcase
        case (t0_code) // [R7]
            3'b000: n.t0_tick = tick12;
            3'b001: n.t0_tick = q.t0_prev && !t0_pin;
            3'b010: n.t0_tick = 1'b1;
            3'b011: n.t0_tick = osc_rise;
            3'b100: n.t0_tick = tick48;
            3'b101: n.t0_tick = watchdog_prescaler_in;
            3'b110: n.t0_tick = tick192;
            default: n.t0_tick = timer1_overflow_in;
        endcase
        n.load = base_overflow_in && !q.tmr_ctrl[`APCS_B_LOCK]; // [R4]
        n.ch4 = q.cap_sel[`APCS_B_C4S] ? comparator_output_in
                                       : q.misc_s2[1]; // [R18]
        n.ch2 = q.cap_sel[`APCS_B_C2S] ? q.misc_s2[0]
                                       : q.misc_s2[2]; // [R19]
        for (int k = 0; k < `APCS_NFUNC; k++) begin
            n.sense[k] = q.pin_s2[fpin[k]];
        end
        for (int p = 0; p < `APCS_NPIN; p++) begin
            n.alt[p] = hit[p];
            n.drive[p] = hval[p];
            n.oe[p] = hoe[p];
        end
        if (sys_rst_in) begin
            n = '0;
            n.tmr_ctrl = `APCS_RST_TMR_CTRL;
            n.pin_sel0 = `APCS_RST_PIN_SEL0;
            n.pin_sel1 = `APCS_RST_PIN_SEL1;
            n.cap_sel = `APCS_RST_CAP_SEL;
            n.page = `APCS_RST_PAGE;
        end
    end

    // State register
    always_ff @(posedge core_clk_in) begin
        q <= n;
    end

    // Outputs straight from the state register
    assign sfr_rdata_out = q.rdata;
    assign pwm_buffer_load_out = q.load;
    assign capture_update_lock_out = q.tmr_ctrl[`APCS_B_LOCK];
    assign timer0_tick_out = q.t0_tick;
    assign timer1_tick_out = q.t1_tick;
    assign capture_ch4_out = q.ch4;
    assign capture_ch2_out = q.ch2;
    assign comparator_filter_hi_out = q.pin_sel1[`APCS_B_CMPFLT];
    assign func_sense_out = q.sense;
    assign pin_drive_out = q.drive;
    assign pin_oe_out = q.oe;
    assign pin_alt_out = q.alt;

    // Checks on the registered behaviour
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_start_set;
        bus_start_seen_in |=> q.tmr_ctrl[`APCS_B_START] ##1
            (q.tmr_ctrl[`APCS_B_START] || $past(sfr_wr_in));
    endproperty
    a_start_set: assert property (p_start_set) // [R1]
        else $error("start flag not set");

    property p_stop_clear;
        (sfr_wr_in && sfr_addr_in == 8'ha3 && !sfr_wdata_in[6] &&
         !bus_stop_seen_in) |=> !q.tmr_ctrl[`APCS_B_STOP];
    endproperty
    a_stop_clear: assert property (p_stop_clear) // [R2]
        else $error("stop flag not cleared");

    property p_rsvd_read;
        (sfr_rd_in && sfr_addr_in == 8'ha3) |=> !sfr_rdata_out[5];
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) // [R3]
        else $error("reserved bit reads one");

    property p_lock;
        base_overflow_in |=>
            (pwm_buffer_load_out == !$past(capture_update_lock_out));
    endproperty
    a_lock: assert property (p_lock) // [R4]
        else $error("buffered load ignores lock");

    property p_t1_fast;
        (t1_code == 2'b10) |=> timer1_tick_out;
    endproperty
    a_t1_fast: assert property (p_t1_fast) // [R6]
        else $error("timer 1 not on system clock");

    // No second tick soon after a divide-by-192 tick
    property p_t0_slow;
        (timer0_tick_out && $past(t0_code) == 3'b110) |=>
            (!timer0_tick_out || $past(t0_code) != 3'b110) [*8];
    endproperty
    a_t0_slow: assert property (p_t0_slow) // [R7]
        else $error("timer 0 divide by 192 too fast");

    property p_cmp_pin;
        q.pin_sel1[`APCS_B_CMPOE] |=> pin_alt_out[20] && pin_oe_out[20]
            && (pin_drive_out[20] == $past(comparator_output_in));
    endproperty
    a_cmp_pin: assert property (p_cmp_pin) // [R17]
        else $error("comparator not on P6.1");

    property p_beep_pin;
        (q.pin_sel0[`APCS_F_BEEP] != 2'b00) |=> pin_alt_out[17];
    endproperty
    a_beep_pin: assert property (p_beep_pin) // [R11]
        else $error("beeper does not own P4.4");

    property p_page_guard;
        (sfr_wr_in && sfr_addr_in == 8'ha4 && q.page != 4'h0)
            |=> $stable(q.pin_sel0);
    endproperty
    a_page_guard: assert property (p_page_guard) // [R23]
        else $error("page 0 register written off page");

    property p_t0_pin;
        (q.tmr_ctrl[`APCS_B_TIMER0_CLOCK_OUT_EN] && q.pin_sel0[7:6] == 2'b00)
            |=> pin_alt_out[13] && (pin_drive_out[13] ==
                $past(func_drive_in[0]));
    endproperty
    a_t0_pin: assert property (p_t0_pin) // [R10]
        else $error("timer 0 clock not on P3.4");
endmodule : apcs_top

// >>> tb/apcs_pin_model.sv
module apcs_pin_model (
    input wire logic [20:0] drive_in, // Pin value from block
    input wire logic [20:0] oe_in, // Pin enable from block
    output logic [20:0] level_out // Wire level seen by block
);
    timeunit 1ns;
    timeprecision 1ns;
    // Undriven pins float high through the pull-up
    assign level_out = (drive_in & oe_in) | ~oe_in;
endmodule : apcs_pin_model

// >>> tb/tb_top.sv
`include "apcs_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, wr = 0, rd = 0, st = 0, sp = 0, ov = 0;
    logic cmp = 0, osc = 0, cs = 0, ld, lk, t0, t1, c4, c2, cf;
    logic [7:0] ad = 0, wd = 0, rdat;
    logic [17:0] fen = 0, fs;
    logic [20:0] g = '1, pd, po, pa, lvl;
    int n_fail = 0, check_count = 0, n;
    // Timer control row keeps bit 5 at zero
    logic [31:0] rows [6] = '{32'ha3_00_df_1f, 32'ha4_00_ff_ff,
        32'ha4_01_ff_fb, 32'ha4_02_ff_ff, 32'ha4_03_ff_00, 32'h55_00_ff_00};
    logic [31:0] divs [3] = '{32'h00_00_0078, 32'h01_00_01e0,
        32'h01_04_0780};
    apcs_top u_dut (.core_clk_in(clk), .sys_rst_in(rst), .sfr_addr_in(ad),
        .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wd),
        .sfr_rdata_out(rdat), .bus_start_seen_in(st),
        .bus_stop_seen_in(sp), .base_overflow_in(ov),
        .pwm_buffer_load_out(ld), .capture_update_lock_out(lk),
        .timer0_counter_select_in(cs), .timer1_counter_select_in(cs),
        .low_speed_rc_osc_in(osc), .watchdog_prescaler_in(1'b0),
        .timer1_overflow_in(1'b0), .timer0_tick_out(t0),
        .timer1_tick_out(t1), .comparator_output_in(cmp),
        .capture_ch4_pin_in(osc), .capture_ch2_pin_in(1'b1),
        .capture_ch4_out(c4), .capture_ch2_out(c2),
        .comparator_filter_hi_out(cf), .func_en_in(fen),
        .func_drive_in(18'h0), .func_oe_in(18'h0), .func_sense_out(fs),
        .pin_in(lvl), .gpio_drive_in(g), .gpio_oe_in(g),
        .pin_drive_out(pd), .pin_oe_out(po), .pin_alt_out(pa));
    apcs_pin_model u_pins (.drive_in(pd), .oe_in(po), .level_out(lvl));
    // Clocks; oscillator well below half the system clock
    always #4 clk = ~clk;
    always #44 osc = ~osc;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        ad = a;
        wd = d;
        wr = 1;
        @(posedge clk) #1;
        wr = 0;
    endtask : wrt
    task automatic rdr(input logic [7:0] a);
        @(posedge clk) #1;
        ad = a;
        rd = 1;
        @(posedge clk) #1;
        rd = 0;
    endtask : rdr
    // Overflow pulse, then count load pulses
    task automatic ovp;
        @(posedge clk) #1;
        ov = 1;
        n = 0;
        repeat (4) @(posedge clk) #1 begin
            ov = 0;
            n += int'(ld === 1'b1);
        end
    endtask : ovp
    task automatic cyc(input int k);
        repeat (2) @(posedge clk);
        n = 0;
        repeat (k) @(posedge clk) #1 n += int'(t0 === 1'b1);
    endtask : cyc
    task automatic print_verdict;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 0;
        rdr(`APCS_ADDR_TMR_CTRL);
        chk(rdat, `APCS_RST_TMR_CTRL);
        rdr(`APCS_ADDR_PIN_SEL);
        chk(rdat, `APCS_RST_PIN_SEL0);
        // Timer control, paged and unmapped register rows
        foreach (rows[i]) begin
            wrt(`APCS_ADDR_PAGE_IDX, rows[i][23:16]);
            wrt(rows[i][31:24], rows[i][15:8]);
            rdr(rows[i][31:24]);
            chk(rdat, rows[i][7:0]);
        end
        // Bus condition flags
        @(posedge clk) #1;
        st = 1;
        sp = 1;
        @(posedge clk) #1;
        st = 0;
        sp = 0;
        rdr(8'ha3);
        chk(rdat[7:6], 2'h3);
        wrt(8'ha3, 8'h1c);
        rdr(8'ha3);
        chk(rdat, 8'h1c);
        chk(lk, 1'h1);
        ovp;
        chk(n, 32'h0);
        chk(t1, 1'h1);
        wrt(8'ha3, 8'h00);
        ovp;
        chk(n, 32'h1);
        // Timer 0 prescaled rates, ten ticks per window
        wrt(`APCS_ADDR_PAGE_IDX, 8'h00);
        foreach (divs[i]) begin
            wrt(8'ha4, divs[i][31:24]);
            wrt(8'ha3, divs[i][23:16]);
            cyc(int'(divs[i][15:0]));
            chk(n, 32'ha);
        end
        // Comparator output, SPI select, channel 4 source
        fen[8] = 1;
        wrt(`APCS_ADDR_PAGE_IDX, 8'h01);
        wrt(8'ha4, 8'h0a);
        wrt(`APCS_ADDR_PAGE_IDX, 8'h02);
        wrt(8'ha4, 8'h80);
        repeat (3) @(posedge clk) #1;
        chk(pa[20], 1'h1);
        chk(pd[20], 1'h0);
        chk(pa[13], 1'h1);
        chk(po[20], 1'h1);
        chk(po[13], 1'h0);
        chk(fs[8], 1'h1);
        chk(cf, 1'h0);
        chk(c2, 1'h1);
        cmp = 1;
        repeat (4) @(posedge clk) #1;
        chk(pd[20], 1'h1);
        chk(c4, 1'h1);
        print_verdict;
    end
endmodule : tb_top
